// ### rtl/gpx_pkg.sv
/*
 * Constants and types shared by the two-wire slave of the GPIO expander.
 * Assumes a 250 MHz core clock; all counts are derived here from it.
 */
package gpx_pkg;
  localparam int          CLK_KHZ       = 250000;
  localparam int          TMO_MS        = 31;
  localparam int          TMO_CYC       = TMO_MS * CLK_KHZ;
  localparam int          TMO_W         = 23;
  localparam logic [4:0]  ADDR_FIXED    = 5'h13;
  localparam logic [7:0]  CFG_OFFSET    = 8'h27;
  localparam int          CFG_TMO_BIT   = 7;
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  localparam logic [7:0]  PTR_RESET     = 8'h00;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  // Strap node codes delivered by the pad logic
  localparam logic [1:0]  STRAP_GND     = 2'h0;
  localparam logic [1:0]  STRAP_VDD     = 2'h1;
  localparam logic [1:0]  STRAP_SDA     = 2'h2;
  localparam logic [1:0]  STRAP_SCL     = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_WDATA,
    ST_ACK,
    ST_TX,
    ST_MACK,
    ST_IGNORE
  } gpx_state_t;
endpackage

// ### rtl/gpx_sync.sv
/*
 * Two-flop synchroniser for a bundle of independent level inputs.
 * Assumes each bit is a slow level; bits are not coherent with each other.
 */
`timescale 1ns/1ns
module gpx_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // Idle bus level is high, so reset to ones avoids a false start
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '1;
      q    <= '1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ### rtl/gpx_i2c_slave.sv
/*
 * Two-wire serial slave of the GPIO expander: start/stop detection, address
 * match with strap-selected low bits, command pointer with autoincrement,
 * register access port toward the register file, and bus timeout.
 * Assumes SCL and SDA are pin levels from another domain, the register file
 * answers reg_rdata one cycle after reg_rd, and SCL half periods last many
 * core clock cycles.
 */
// Operation
// - The clock pin is input only and the data pin can only be pulled low.
// - Both lines idle high and a stop condition frees the bus.
// - Data falling with clock high is a start, rising is a stop.
// - One bit per clock pulse, held stable while the clock is high.
// - A ninth clocked bit is driven low by the receiver of each byte.
// - The address is five fixed high bits plus two bits from the strap.
// - The bit after the address selects write when zero, read when one.
// - The first write byte sets the pointer and nothing else.
// - Each write data byte goes to the pointer, which then advances.
// - Reads start at the stored pointer and advance after each byte.
// - Bus timeout is on when configuration bit seven is zero.
// - A line held low about 31 ms in a transfer resets the interface.
`timescale 1ns/1ns
module gpx_i2c_slave
  import gpx_pkg::*;
#(
  parameter int TMO_CYCLES = gpx_pkg::TMO_CYC
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [1:0] address_strap_input,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] device_configuration
);
  import gpx_pkg::*;

  if (TMO_CYCLES < 2 || TMO_CYCLES >= (1 << TMO_W)) begin : g_bad_tmo
    $error("TMO_CYCLES outside counter range");
  end

  function automatic logic is_cfg(input logic [7:0] a);
    return a == CFG_OFFSET;
  endfunction

  logic [3:0]  pins_s;
  logic        scl_s;
  logic        sda_s;
  logic        scl_q;
  logic        sda_q;
  logic [1:0]  strap_s;
  logic [1:0]  strap_wait;
  logic        cmd_next;
  logic [1:0]  addr_lo;
  gpx_state_t  state;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  ptr;
  logic        rw;
  logic        fetch;
  logic [TMO_W-1:0] tmo_cnt;

  gpx_sync #(
    .W (4)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({address_strap_input, sda_in, scl_in}),
    .q      (pins_s)
  );

  // The clock line is only ever sampled here
  assign scl_s   = pins_s[0];
  assign sda_s   = pins_s[1];
  assign strap_s = pins_s[3:2];

  wire scl_rise   = scl_s && !scl_q;
  wire scl_fall   = !scl_s && scl_q;
  wire start_det  = scl_s && scl_q && sda_q && !sda_s;
  wire stop_det   = scl_s && scl_q && !sda_q && sda_s;
  wire rx_state   = state == ST_ADDR || state == ST_CMD ||
                    state == ST_WDATA;
  wire byte_end   = rx_state && scl_fall && bit_cnt == BITS_PER_BYTE;
  wire addr_hit   = shreg[7:1] == {ADDR_FIXED, addr_lo};
  wire addr_miss  = byte_end && state == ST_ADDR && !addr_hit;
  wire tmo_en     = !device_configuration[CFG_TMO_BIT];
  wire tmo_count  = tmo_en && state != ST_IDLE && (!scl_s || !sda_s);
  wire tmo_fire   = tmo_count &&
                    tmo_cnt == TMO_W'(TMO_CYCLES - 1);
  wire [7:0] next_ptr = ptr + 8'h01;
  wire [7:0] rd_mux   = is_cfg(reg_addr) ? device_configuration : reg_rdata;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // Strap caught once, after the synchroniser has flushed its reset ones
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_wait <= 2'h0;
      addr_lo    <= STRAP_GND;
    end else if (strap_wait != 2'h3) begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == 2'h2) begin
        addr_lo <= strap_s;
      end
    end
  end

  // Counts only continuous low time; any idle-high moment restarts it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tmo_cnt <= '0;
    end else if (!tmo_count || tmo_fire) begin
      tmo_cnt <= '0;
    end else begin
      tmo_cnt <= tmo_cnt + TMO_W'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state                <= ST_IDLE;
      sda_oe               <= 1'b0;
      bit_cnt              <= 4'h0;
      shreg                <= 8'h00;
      ptr                  <= PTR_RESET;
      rw                   <= 1'b0;
      fetch                <= 1'b0;
      reg_addr             <= PTR_RESET;
      reg_wdata            <= 8'h00;
      reg_wr               <= 1'b0;
      reg_rd               <= 1'b0;
      device_configuration <= CFG_RESET;
    end else begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      fetch  <= reg_rd;
      if (fetch) begin
        shreg <= rd_mux;
      end
      if (tmo_fire) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (start_det) begin
        state   <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (stop_det) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_CMD, ST_WDATA: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (byte_end) begin
              bit_cnt <= 4'h0;
              sda_oe  <= 1'b1;
              state   <= ST_ACK;
              if (state == ST_ADDR) begin
                rw <= shreg[0];
                if (!addr_hit) begin
                  sda_oe <= 1'b0;
                  state  <= ST_IGNORE;
                end else if (shreg[0]) begin
                  reg_rd   <= 1'b1;
                  reg_addr <= ptr;
                end
              end else if (state == ST_CMD) begin
                ptr <= shreg;
              end else begin
                reg_addr  <= ptr;
                reg_wdata <= shreg;
                reg_wr    <= 1'b1;
                ptr       <= next_ptr;
                if (is_cfg(ptr)) begin
                  device_configuration <= shreg;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (rw) begin
                sda_oe  <= !shreg[7];
                shreg   <= {shreg[6:0], 1'b0};
                bit_cnt <= 4'h1;
                state   <= ST_TX;
              end else begin
                sda_oe <= 1'b0;
                state  <= cmd_next ? ST_CMD : ST_WDATA;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt == BITS_PER_BYTE) begin
                sda_oe <= 1'b0;
                ptr    <= next_ptr;
                state  <= ST_MACK;
              end else begin
                sda_oe  <= !shreg[7];
                shreg   <= {shreg[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              if (!sda_s) begin
                reg_rd   <= 1'b1;
                reg_addr <= ptr;
                bit_cnt  <= 4'h0;
                state    <= ST_TX;
              end else begin
                state <= ST_IGNORE;
              end
            end
          end
          ST_IGNORE, ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // First write byte after an address ack is the command byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_next <= 1'b0;
    end else if (byte_end) begin
      cmd_next <= state == ST_ADDR;
    end
  end

  AST_OE_ONLY_ACK_TX: assert property (@(posedge clk) disable iff (!arst_n)
    sda_oe |-> (state == ST_ACK || state == ST_TX))
    else $error("data line pulled outside ack or transmit");

  AST_START_ADDR: assert property (@(posedge clk) disable iff (!arst_n)
    (start_det && !tmo_fire) |=> (state == ST_ADDR && bit_cnt == 4'h0))
    else $error("start not followed by address phase");

  AST_STOP_FREE: assert property (@(posedge clk) disable iff (!arst_n)
    (stop_det && !tmo_fire && !start_det) |=> (state == ST_IDLE && !sda_oe))
    else $error("stop did not free the bus");

  AST_ACK_HELD: assert property (@(posedge clk) disable iff (!arst_n)
    (state == ST_ACK && scl_s && !stop_det && !start_det && !tmo_fire)
      |-> sda_oe)
    else $error("ack not held low through clock high");

  AST_TX_STABLE: assert property (@(posedge clk) disable iff (!arst_n)
    (scl_s && $past(scl_s) && !$past(tmo_fire)) |-> $stable(sda_oe))
    else $error("data changed while clock high");

  AST_MISS_IGNORE: assert property (@(posedge clk) disable iff (!arst_n)
    (addr_miss && !tmo_fire && !start_det && !stop_det)
      |=> (state == ST_IGNORE && !sda_oe) [*2])
    else $error("foreign address was acknowledged");

  AST_WR_ADVANCE: assert property (@(posedge clk) disable iff (!arst_n)
    reg_wr |-> (ptr == reg_addr + 8'h01))
    else $error("pointer did not advance after write");

  AST_CFG_STORE: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_wr && is_cfg(reg_addr)) |-> device_configuration == reg_wdata)
    else $error("configuration write not stored");

  AST_TMO_OFF: assert property (@(posedge clk) disable iff (!arst_n)
    device_configuration[CFG_TMO_BIT] |=> tmo_cnt == '0)
    else $error("timeout counting while disabled");

  AST_TMO_RESET: assert property (@(posedge clk) disable iff (!arst_n)
    tmo_fire |=> (state == ST_IDLE && !sda_oe && tmo_cnt == '0))
    else $error("timeout did not reset the interface");

  AST_CMD_ONLY: assert property (@(posedge clk) disable iff (!arst_n)
    (byte_end && state == ST_CMD) |=> (!reg_wr && ptr == $past(shreg)))
    else $error("command byte did more than set the pointer");

  AST_RD_FROM_PTR: assert property (@(posedge clk) disable iff (!arst_n)
    reg_rd |-> ##2 (state != ST_TX || reg_addr == ptr))
    else $error("read not taken from the stored pointer");
endmodule

// ### sim/gpx_master_model.sv
/*
 * Bus master model for the two-wire slave: start, stop, byte transfers.
 * Assumes pull-ups on both lines; clk only paces the 48 ns link period.
 */
`timescale 1ns/1ns
module gpx_master_model (
  input  wire logic clk,
  input  wire logic sda_oe,
  input  wire logic sda_out,
  output logic      scl,
  output logic      sda
);
  logic m_sda = 1'b1;
  // Wired-AND with pull-up; the slave can only pull low
  assign sda = m_sda & ~(sda_oe & ~sda_out);
  // Both lines idle high
  initial scl = 1'b1;
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Master alone moves the clock line
  task automatic drv(input logic c, input logic s, input int n);
    scl   = c;
    m_sda = s;
    wt(n);
  endtask
  // One bit per pulse, data moves only while SCL is low
  task automatic bit_io(input logic b, output logic q);
    drv(1'b0, b, 4);
    drv(1'b1, b, 3);
    q = sda;
    drv(1'b1, b, 3);
    drv(1'b0, b, 2);
  endtask
  // Also serves as repeated start; SDA falls with SCL high
  task automatic start();
    drv(scl, 1'b1, 6);
    drv(1'b1, 1'b1, 3);
    drv(1'b1, 1'b0, 3);
    drv(1'b0, 1'b0, 2);
  endtask
  // SDA rises with SCL high and the bus goes idle
  task automatic stop();
    drv(1'b0, 1'b0, 6);
    drv(1'b1, 1'b0, 3);
    drv(1'b1, 1'b1, 6);
  endtask
  // MSB first; ninth bit is the slave's answer
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) bit_io(b[i], q);
    bit_io(1'b1, q);
    ack = ~q;
  endtask
  // Master acknowledges all but the last byte
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, q);
  endtask
endmodule

// ### sim/tb.sv
/*
 * Self-checking bench for the two-wire slave with a simple register file.
 * Assumes the register file answers one clock after the address settles.
 */
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("Error at %0t: got %0h want %0h", $time, (a), (e)); end end
module tb;
  import gpx_pkg::*;
  // Short timeout keeps the run brief
  localparam int         TMO = 2000;
  localparam logic [7:0] AW  = {ADDR_FIXED, 2'h3, 1'b0};
  localparam logic [7:0] AR  = {ADDR_FIXED, 2'h3, 1'b1};
  logic       clk       = 1'b0;
  logic       arst_n    = 1'b0;
  logic [1:0] strap     = 2'h0;
  logic [7:0] reg_rdata = 8'h00;
  logic       scl, sda, sda_out, sda_oe, reg_wr, reg_rd, ack, q;
  logic [7:0] reg_addr, reg_wdata, device_configuration, d;
  logic [7:0] regs [256];
  int         wr_cnt      = 0;
  int         errors      = 0;
  int         checks_done = 0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    reg_rdata <= regs[reg_addr];
    if (reg_wr) begin
      regs[reg_addr] <= reg_wdata;
      wr_cnt <= wr_cnt + 1;
    end
  end
  gpx_i2c_slave #(.TMO_CYCLES(TMO)) dut (
    .clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .address_strap_input(strap),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .device_configuration(device_configuration));
  gpx_master_model m (
    .clk(clk), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda(sda));
  task automatic do_reset(input logic [1:0] s);
    arst_n = 1'b0;
    strap = s;
    repeat (4) @(posedge clk);
    #1;
    arst_n = 1'b1;
    m.wt(6);
  endtask
  task automatic wr(input logic [7:0] cmd, input int n,
                    input logic [23:0] dat, input logic keep);
    m.start();
    m.wbyte(AW, ack);
    `CHK(ack, 1'b1);
    m.wbyte(cmd, ack);
    `CHK(ack, 1'b1);
    for (int i = n - 1; i >= 0; i--) begin
      m.wbyte(dat[8*i +: 8], ack);
      `CHK(ack, 1'b1);
    end
    if (!keep) m.stop();
  endtask
  task automatic rd(input int n, input logic [23:0] e);
    m.start();
    m.wbyte(AR, ack);
    `CHK(ack, 1'b1);
    for (int i = n - 1; i >= 0; i--) begin
      m.rbyte(i == 0, d);
      `CHK(d, e[8*i +: 8]);
    end
    m.stop();
  endtask
  // SCL parked low while the slave pulls its acknowledge
  task automatic stall(input logic held);
    m.start();
    for (int i = 7; i >= 0; i--) m.bit_io(AW[i], q);
    m.wt(TMO - 100);
    `CHK(sda_oe, 1'b1);
    m.wt(200);
    `CHK(sda_oe, held);
    if (held) begin
      m.bit_io(1'b1, q);
      `CHK(q, 1'b0);
    end
    m.stop();
  endtask
  task automatic summarize();
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    for (int s = 0; s < 4; s++) begin
      do_reset(s[1:0]);
      `CHK(sda_oe, 1'b0);
      `CHK(sda_out, 1'b0);
      `CHK(device_configuration, CFG_RESET);
      for (int a = 0; a < 4; a++) begin
        m.start();
        m.wbyte({ADDR_FIXED, a[1:0], 1'b0}, ack);
        `CHK(ack, a == s);
        m.wbyte(8'h30, ack);
        `CHK(ack, a == s);
        m.stop();
      end
    end
    `CHK(wr_cnt, 0);
    // Burst across the top of the pointer range
    wr(8'hfe, 3, 24'ha53c69, 1'b0);
    `CHK(regs[8'hfe], 8'ha5);
    `CHK(regs[8'hff], 8'h3c);
    `CHK(regs[8'h00], 8'h69);
    regs[8'h40] = 8'h5a;
    regs[8'h41] = 8'hc3;
    regs[8'h42] = 8'h96;
    wr(8'h40, 0, 24'h0, 1'b0);
    `CHK(wr_cnt, 3);
    rd(2, 24'h5ac3);
    rd(1, 24'h96);
    wr(8'h00, 0, 24'h0, 1'b1);
    rd(1, 24'h69);
    wr(CFG_OFFSET, 1, 24'h80, 1'b0);
    `CHK(device_configuration, 8'h80);
    wr(CFG_OFFSET, 0, 24'h0, 1'b0);
    rd(1, 24'h80);
    stall(1'b1);
    wr(CFG_OFFSET, 1, 24'h00, 1'b0);
    `CHK(device_configuration, 8'h00);
    stall(1'b0);
    wr(CFG_OFFSET, 0, 24'h0, 1'b1);
    rd(1, 24'h00);
    summarize();
  end
  // Run needs about 12k cycles; about eight times that cuts a hang
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule
